// ===== inc/epdc_pkg.sv
// Constants and carrier types of the edge preset down-counter bank.
// Assumes one 50 MHz core clock and a simple strobe register port.
// Function
// - Decrement present count when count input is ON and was OFF last execution.
// - Leave present count unchanged when count input steady or falling.
// - Set completion flag when count reaches zero; hold until reset.
// - Reload present count with preset when reset input goes OFF to ON.
// - No decrementing while reset input stays ON.
// - After reset goes OFF, count down again from preset on rising inputs.
// - Keep present count through interlock and power loss; no implicit reset. Here RST_N_I clears pv_reg to 0.
// - Non-BCD preset: keep executing; loaded value is undefined.
// - Raise fault indicator when preset value is not BCD.
// - Raise fault indicator on non-BCD or out-of-range indirect operand.
// - Provide a one-second period pulse bit usable as count input.
package epdc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int EPDC_NCNT = 4;
  localparam int EPDC_DM_DEPTH = 16;
  localparam int EPDC_DIGITS = 4;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] EPDC_OFS_SCAN = 8'h00;
  localparam logic [7:0] EPDC_OFS_SRC = 8'h04;
  localparam logic [7:0] EPDC_OFS_DONE = 8'h08;
  localparam logic [7:0] EPDC_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] EPDC_OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] EPDC_OFS_PULSE = 8'h14;
  localparam logic [7:0] EPDC_OFS_PRESET = 8'h20;
  localparam logic [7:0] EPDC_OFS_PV = 8'h30;
  localparam logic [7:0] EPDC_OFS_DM = 8'h40;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EPDC_SCAN_CNT_LSB = 0;
  localparam int EPDC_SCAN_RST_LSB = 4;
  localparam int EPDC_SCAN_ILK_BIT = 8;
  localparam int EPDC_IRQ_DONE_LSB = 0;
  localparam int EPDC_IRQ_FAULT_BIT = 4;
  localparam int EPDC_IRQ_W = 5;
  localparam int EPDC_PRE_IND_BIT = 21;
  localparam int EPDC_PRE_IDX_LSB = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] EPDC_PV_RST = 16'h0000;
  localparam logic [21:0] EPDC_PRESET_RST = 22'h000000;
  localparam logic [3:0] EPDC_SRC_RST = 4'h0;
  localparam logic [4:0] EPDC_MASK_RST = 5'h00;

  // ---------------------------------------------------------------
  // Timing of the one-second pulse bit
  // ---------------------------------------------------------------
  localparam int EPDC_CLK_HZ = 50_000_000;
  localparam int EPDC_PULSE_PERIOD_MS = 1000;
  localparam int EPDC_PULSE_HALF_CYC =
    (EPDC_CLK_HZ / 1000) * EPDC_PULSE_PERIOD_MS / 2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic interlock;
    logic [EPDC_NCNT-1:0] rst;
    logic [EPDC_NCNT-1:0] cnt;
  } epdc_scan_type;

  typedef struct packed {
    logic indirect;
    logic [4:0] dm_idx;
    logic [15:0] value;
  } epdc_preset_type;

endpackage

// ===== src/epdc_pulse.sv
// One-second clock pulse bit for the counter bank.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/100ps
module epdc_pulse
  import epdc_pkg::*;
#(
  parameter int HALF_CYC = EPDC_PULSE_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic pulse_o
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic pulse_reg;
  logic pulse_next;

  // --------------------------------------------------------------
  // Half period counter, toggles the level
  // --------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg + 32'h00000001;
    pulse_next = pulse_reg;
    if (cnt_reg == 32'(HALF_CYC - 1)) begin
      cnt_next = 32'h00000000;
      pulse_next = ~pulse_reg;
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 32'h00000000;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_o = pulse_reg;

endmodule

// ===== src/epdc_top.sv
// Bank of edge-triggered BCD preset down-counters with register port.
// Assumes software drives one scan per write to the scan register.
`timescale 1ns/100ps
module epdc_top
  import epdc_pkg::*;
#(
  parameter int PULSE_HALF_CYC = EPDC_PULSE_HALF_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RD_DATA_O,
  output logic [EPDC_NCNT-1:0] DONE_O,
  output logic FAULT_O,
  output logic IRQ_O
);

  // ---------------------------------------------------------------
  // BCD helpers
  // ---------------------------------------------------------------
  function automatic logic is_bcd(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < EPDC_DIGITS; d++) begin
      if (v[d*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int d = 0; d < EPDC_DIGITS; d++) begin
      if (borrow) begin
        if (v[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = 4'h9;
        end else begin
          r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Two stage reset release
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // One-second pulse source
  // ---------------------------------------------------------------
  logic pulse;

  epdc_pulse #(
    .HALF_CYC(PULSE_HALF_CYC)
  ) u_pulse (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .pulse_o(pulse)
  );

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  epdc_scan_type scan;
  logic scan_go;
  logic wr_src;
  logic wr_mask;
  logic wr_stat;
  logic wr_pre;
  logic wr_dm;

  // Strobe decode
  always_comb begin
    scan = epdc_scan_type'(WR_DATA_I[EPDC_SCAN_ILK_BIT:0]);
    scan_go = WR_I && (ADDR_I == EPDC_OFS_SCAN) && !scan.interlock;
    wr_src = WR_I && (ADDR_I == EPDC_OFS_SRC);
    wr_mask = WR_I && (ADDR_I == EPDC_OFS_IRQ_MASK);
    wr_stat = WR_I && (ADDR_I == EPDC_OFS_IRQ_STAT);
    wr_pre = WR_I && (ADDR_I[7:4] == EPDC_OFS_PRESET[7:4]);
    wr_dm = WR_I && (ADDR_I[7:6] == EPDC_OFS_DM[7:6]);
  end

  // ---------------------------------------------------------------
  // Configuration registers and data memory area
  // ---------------------------------------------------------------
  logic [EPDC_NCNT-1:0] src_reg;
  logic [EPDC_NCNT-1:0] src_next;
  logic [EPDC_IRQ_W-1:0] mask_reg;
  logic [EPDC_IRQ_W-1:0] mask_next;
  epdc_preset_type preset_reg [EPDC_NCNT];
  epdc_preset_type preset_next [EPDC_NCNT];
  logic [15:0] dm_reg [EPDC_DM_DEPTH];
  logic [15:0] dm_next [EPDC_DM_DEPTH];

  // Next values of software-written state
  always_comb begin
    src_next = src_reg;
    mask_next = mask_reg;
    preset_next = preset_reg;
    dm_next = dm_reg;
    if (wr_src) begin
      src_next = WR_DATA_I[EPDC_NCNT-1:0];
    end
    if (wr_mask) begin
      mask_next = WR_DATA_I[EPDC_IRQ_W-1:0];
    end
    if (wr_pre) begin
      preset_next[ADDR_I[3:2]] = epdc_preset_type'(WR_DATA_I[21:0]);
    end
    if (wr_dm) begin
      dm_next[ADDR_I[5:2]] = WR_DATA_I[15:0];
    end
  end

  // Registers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      src_reg <= EPDC_SRC_RST;
      mask_reg <= EPDC_MASK_RST;
      for (int i = 0; i < EPDC_NCNT; i++) begin
        preset_reg[i] <= EPDC_PRESET_RST;
      end
      for (int i = 0; i < EPDC_DM_DEPTH; i++) begin
        dm_reg[i] <= EPDC_PV_RST;
      end
    end else begin
      src_reg <= src_next;
      mask_reg <= mask_next;
      preset_reg <= preset_next;
      dm_reg <= dm_next;
    end
  end

  // ---------------------------------------------------------------
  // Counter bank
  // ---------------------------------------------------------------
  logic [15:0] pv_w [EPDC_NCNT];
  logic [EPDC_NCNT-1:0] done_w;
  logic [EPDC_NCNT-1:0] done_ev;
  logic [EPDC_NCNT-1:0] fault_ev;

  for (genvar g = 0; g < EPDC_NCNT; g++) begin : g_cnt
    logic [15:0] pv_reg;
    logic [15:0] pv_next;
    logic done_reg;
    logic done_next;
    logic last_cnt_reg;
    logic last_cnt_next;
    logic last_rst_reg;
    logic last_rst_next;
    logic [15:0] pre_val;
    logic bad_pre;
    logic cnt_cond;
    logic rst_cond;

    // Preset resolution, direct or from data memory
    always_comb begin
      bad_pre = 1'b0;
      pre_val = preset_reg[g].value;
      if (preset_reg[g].indirect) begin
        if (preset_reg[g].dm_idx[4]) begin
          bad_pre = 1'b1;
          pre_val = EPDC_PV_RST;
        end else begin
          pre_val = dm_reg[preset_reg[g].dm_idx[3:0]];
        end
      end
      if (!is_bcd(pre_val)) begin
        bad_pre = 1'b1;
      end
    end

    // One execution of this counter per scan strobe
    always_comb begin
      cnt_cond = src_reg[g] ? pulse : scan.cnt[g];
      rst_cond = scan.rst[g];
      pv_next = pv_reg;
      done_next = done_reg;
      last_cnt_next = last_cnt_reg;
      last_rst_next = last_rst_reg;
      done_ev[g] = 1'b0;
      fault_ev[g] = 1'b0;
      if (scan_go) begin
        fault_ev[g] = bad_pre;
        last_cnt_next = cnt_cond;
        last_rst_next = rst_cond;
        if (rst_cond && !last_rst_reg) begin
          // Non-BCD value loads as is, execution goes on
          pv_next = pre_val;
          done_next = 1'b0;
        end else if (rst_cond) begin
          pv_next = pv_reg;
        end else if (cnt_cond && !last_cnt_reg
                     && pv_reg != EPDC_PV_RST) begin
          pv_next = bcd_dec(pv_reg);
          if (bcd_dec(pv_reg) == EPDC_PV_RST) begin
            done_next = 1'b1;
            done_ev[g] = 1'b1;
          end
        end
        // Steady or falling input leaves the count alone
      end
    end

    // Counter state; interlock keeps it
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        pv_reg <= EPDC_PV_RST;
        done_reg <= 1'b0;
        last_cnt_reg <= 1'b0;
        last_rst_reg <= 1'b0;
      end else begin
        pv_reg <= pv_next;
        done_reg <= done_next;
        last_cnt_reg <= last_cnt_next;
        last_rst_reg <= last_rst_next;
      end
    end

    assign pv_w[g] = pv_reg;
    assign done_w[g] = done_reg;
  end

  // ---------------------------------------------------------------
  // Interrupt status and read port
  // ---------------------------------------------------------------
  logic [EPDC_IRQ_W-1:0] stat_reg;
  logic [EPDC_IRQ_W-1:0] stat_next;
  logic [EPDC_IRQ_W-1:0] stat_set;
  logic irq_reg;
  logic irq_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // Sticky status, set beats write-one clear
  always_comb begin
    stat_set = '0;
    stat_set[EPDC_IRQ_DONE_LSB +: EPDC_NCNT] = done_ev;
    stat_set[EPDC_IRQ_FAULT_BIT] = |fault_ev;
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~WR_DATA_I[EPDC_IRQ_W-1:0];
    end
    stat_next = stat_next | stat_set;
    irq_next = |(stat_next & mask_next);
  end

  // Read data mux, answered in the next cycle
  always_comb begin
    rd_next = 32'h00000000;
    if (RD_I) begin
      if (ADDR_I == EPDC_OFS_SRC) begin
        rd_next[EPDC_NCNT-1:0] = src_reg;
      end else if (ADDR_I == EPDC_OFS_DONE) begin
        rd_next[EPDC_NCNT-1:0] = done_w;
      end else if (ADDR_I == EPDC_OFS_IRQ_STAT) begin
        rd_next[EPDC_IRQ_W-1:0] = stat_reg;
      end else if (ADDR_I == EPDC_OFS_IRQ_MASK) begin
        rd_next[EPDC_IRQ_W-1:0] = mask_reg;
      end else if (ADDR_I == EPDC_OFS_PULSE) begin
        rd_next[0] = pulse;
      end else if (ADDR_I[7:4] == EPDC_OFS_PRESET[7:4]) begin
        rd_next[21:0] = preset_reg[ADDR_I[3:2]];
      end else if (ADDR_I[7:4] == EPDC_OFS_PV[7:4]) begin
        rd_next[15:0] = pv_w[ADDR_I[3:2]];
      end else if (ADDR_I[7:6] == EPDC_OFS_DM[7:6]) begin
        rd_next[15:0] = dm_reg[ADDR_I[5:2]];
      end
    end
  end

  // Registers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
      irq_reg <= 1'b0;
      rd_reg <= 32'h00000000;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= irq_next;
      rd_reg <= rd_next;
    end
  end

  // Outputs, all from flip-flops
  assign RD_DATA_O = rd_reg;
  assign IRQ_O = irq_reg;
  assign FAULT_O = stat_reg[EPDC_IRQ_FAULT_BIT];
  assign DONE_O = done_w;

endmodule

// ===== tb/epdc_asserts.sv
// Port-level checker for the counter bank.
// Assumes the register map and strobe protocol of epdc_pkg.
`timescale 1ns/100ps
module epdc_asserts
  import epdc_pkg::*;
#(
  parameter int PULSE_HALF_CYC = EPDC_PULSE_HALF_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RD_DATA_O,
  input wire logic [EPDC_NCNT-1:0] DONE_O,
  input wire logic FAULT_O,
  input wire logic IRQ_O
);
  logic [3:0] src_reg;
  logic [3:0] src_next;
  logic [4:0] mask_reg;
  logic [4:0] mask_next;
  logic scan_w;
  logic ilk_w;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ------------------------------------------------------------
  // Shadow of source select and interrupt mask
  // ------------------------------------------------------------
  assign scan_w = WR_I && ADDR_I == EPDC_OFS_SCAN && !WR_DATA_I[8];
  assign ilk_w = WR_I && ADDR_I == EPDC_OFS_SCAN && WR_DATA_I[8];
  // Next shadow values
  always_comb begin
    src_next = src_reg;
    mask_next = mask_reg;
    if (WR_I && ADDR_I == EPDC_OFS_SRC) begin
      src_next = WR_DATA_I[3:0];
    end
    if (WR_I && ADDR_I == EPDC_OFS_IRQ_MASK) begin
      mask_next = WR_DATA_I[4:0];
    end
  end
  // Shadow registers
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_reg <= 4'h0;
      mask_reg <= 5'h00;
    end else begin
      src_reg <= src_next;
      mask_reg <= mask_next;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_rd_done;
    RD_I && ADDR_I == EPDC_OFS_DONE;
  endsequence
  sequence s_ilk;
    ilk_w;
  endsequence
  property p_rd_idle;
    !$past(RD_I) |-> RD_DATA_O == 32'h00000000;
  endproperty
  property p_rd_done;
    s_rd_done |=> RD_DATA_O == {28'h0000000, $past(DONE_O)};
  endproperty
  property p_done_rise;
    |(DONE_O & ~$past(DONE_O)) |-> $past(scan_w) && ((DONE_O &
      ~$past(DONE_O) & ~$past((WR_DATA_I[3:0] | src_reg) &
      ~WR_DATA_I[7:4])) == 4'h0);
  endproperty
  property p_done_fall;
    |($past(DONE_O) & ~DONE_O) |-> $past(scan_w) &&
      (($past(DONE_O) & ~DONE_O & ~$past(WR_DATA_I[7:4])) == 4'h0);
  endproperty
  property p_ilk;
    s_ilk |=> $stable(DONE_O) && $stable(FAULT_O);
  endproperty
  property p_fault_rise;
    $rose(FAULT_O) |-> $past(scan_w);
  endproperty
  property p_fault_fall;
    $fell(FAULT_O) |-> $past(WR_I && ADDR_I == EPDC_OFS_IRQ_STAT &&
      WR_DATA_I[4]);
  endproperty
  property p_irq_mask;
    IRQ_O |-> mask_reg != 5'h00;
  endproperty
  property p_irq_fault;
    FAULT_O && mask_reg[4] |-> IRQ_O;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  a_rd_done: assert property (p_rd_done)
    else $error("done read mismatch");
  a_done_rise: assert property (p_done_rise)
    else $error("done set without qualifying scan");
  a_done_fall: assert property (p_done_fall)
    else $error("done cleared without reset input");
  a_ilk: assert property (p_ilk)
    else $error("interlocked scan changed state");
  a_fault_rise: assert property (p_fault_rise)
    else $error("fault set without scan");
  a_fault_fall: assert property (p_fault_fall)
    else $error("fault cleared without clear write");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt with all masked");
  a_irq_fault: assert property (p_irq_fault)
    else $error("unmasked fault gave no interrupt");
endmodule
bind epdc_top epdc_asserts #(.PULSE_HALF_CYC(PULSE_HALF_CYC)) u_asserts (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
  .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
  .DONE_O(DONE_O), .FAULT_O(FAULT_O), .IRQ_O(IRQ_O));

// ===== tb/epdc_ladder.sv
// Ladder program model: drives scans and register strobes.
// Assumes the bank takes one strobe per edge and never waits.
`timescale 1ns/100ps
module epdc_ladder
  import epdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rd_data_i,
  output logic [7:0] addr_o,
  output logic [31:0] wr_data_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wr_data_o = 32'h00000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One-cycle write; stale data inverted after release
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
  // One-cycle read; data taken mid-cycle while it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(negedge clk_i);
    d = rd_data_i;
  endtask
  // One scan; each slot driven by one instruction only
  task automatic scan(input logic [3:0] c, input logic [3:0] r,
                      input logic i);
    epdc_scan_type s;
    s.interlock = i;
    s.rst = r;
    s.cnt = c;
    wr(EPDC_OFS_SCAN, {23'h000000, s});
  endtask
endmodule

// ===== tb/epdc_top_tb.sv
// Self-checking bench for the counter bank.
// Assumes the ladder model as bus master; short pulse period.
`timescale 1ns/100ps
module epdc_top_tb;
  import epdc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [3:0] done;
  logic fault;
  logic irq;
  int error_cnt = 0;
  int samples_checked = 0;
  // ------------------------------------------------------------
  // Clock, design and program model
  // ------------------------------------------------------------
  always #10 clk = ~clk;
  epdc_top #(.PULSE_HALF_CYC(4)) u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdata), .DONE_O(done), .FAULT_O(fault), .IRQ_O(irq));
  epdc_ladder u_prog (.clk_i(clk), .rd_data_i(rdata), .addr_o(addr),
    .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));
  // ------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_prog.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  task automatic pins(input int n, input logic [31:0] exp);
    repeat (n) @(negedge clk);
    chk("done fault irq", {25'h0, done, fault, irq}, exp);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(EPDC_OFS_SRC, 32'h0);
    rchk(EPDC_OFS_IRQ_MASK, 32'h0);
    rchk(8'hFC, 32'h0);
    rchk(EPDC_OFS_PV, 32'h0);
    u_prog.wr(EPDC_OFS_PRESET, 32'h10);
    u_prog.wr(EPDC_OFS_PRESET + 8'h04, 32'h2);
    u_prog.scan(4'h0, 4'h3, 1'b0);
    rchk(EPDC_OFS_PV, 32'h10);
    u_prog.scan(4'h3, 4'h3, 1'b0);
    u_prog.scan(4'h0, 4'h3, 1'b0);
    u_prog.scan(4'h3, 4'h3, 1'b0);
    rchk(EPDC_OFS_PV, 32'h10);
    u_prog.scan(4'h0, 4'h0, 1'b0);
    u_prog.scan(4'h3, 4'h0, 1'b0);
    rchk(EPDC_OFS_PV, 32'h09);
    u_prog.scan(4'h3, 4'h0, 1'b0);
    rchk(EPDC_OFS_PV, 32'h09);
    u_prog.scan(4'h0, 4'h0, 1'b0);
    rchk(EPDC_OFS_PV, 32'h09);
    u_prog.scan(4'h3, 4'h0, 1'b0);
    pins(1, 32'h08);
    rchk(EPDC_OFS_DONE, 32'h2);
    rchk(EPDC_OFS_IRQ_STAT, 32'h2);
    u_prog.wr(EPDC_OFS_IRQ_MASK, 32'h1F);
    pins(2, 32'h09);
    u_prog.wr(EPDC_OFS_IRQ_STAT, 32'h2);
    pins(2, 32'h08);
    u_prog.scan(4'h0, 4'h0, 1'b0);
    u_prog.scan(4'h2, 4'h0, 1'b0);
    rchk(EPDC_OFS_PV + 8'h04, 32'h0);
    pins(1, 32'h08);
    u_prog.scan(4'h1, 4'h0, 1'b1);
    rchk(EPDC_OFS_PV, 32'h08);
    u_prog.scan(4'h1, 4'h0, 1'b0);
    rchk(EPDC_OFS_PV, 32'h07);
    u_prog.scan(4'h0, 4'h2, 1'b0);
    pins(1, 32'h00);
    rchk(EPDC_OFS_PV + 8'h04, 32'h2);
    // Non-BCD preset, then indirect operands
    u_prog.wr(EPDC_OFS_PRESET + 8'h08, 32'hA5);
    u_prog.scan(4'h0, 4'h4, 1'b0);
    pins(2, 32'h03);
    rchk(EPDC_OFS_PV + 8'h08, 32'hA5);
    u_prog.wr(EPDC_OFS_PRESET + 8'h08, 32'h5);
    u_prog.wr(EPDC_OFS_IRQ_STAT, 32'h10);
    pins(2, 32'h00);
    u_prog.wr(EPDC_OFS_DM + 8'h0C, 32'h1234);
    u_prog.wr(EPDC_OFS_DM + 8'h10, 32'hF0);
    u_prog.wr(EPDC_OFS_PRESET + 8'h0C, 32'h230000);
    u_prog.scan(4'h0, 4'h8, 1'b0);
    rchk(EPDC_OFS_PV + 8'h0C, 32'h1234);
    pins(0, 32'h00);
    u_prog.wr(EPDC_OFS_PRESET + 8'h0C, 32'h300000);
    u_prog.scan(4'h0, 4'h0, 1'b0);
    pins(1, 32'h03);
    u_prog.wr(EPDC_OFS_PRESET + 8'h0C, 32'h1);
    u_prog.wr(EPDC_OFS_IRQ_STAT, 32'h10);
    u_prog.wr(EPDC_OFS_PRESET + 8'h0C, 32'h240000);
    u_prog.scan(4'h0, 4'h0, 1'b0);
    pins(1, 32'h03);
    u_prog.wr(EPDC_OFS_PRESET + 8'h0C, 32'h1);
    u_prog.wr(EPDC_OFS_IRQ_STAT, 32'h1F);
    // Counter 0 timed by the one-second pulse bit
    u_prog.wr(EPDC_OFS_PRESET, 32'h2);
    u_prog.wr(EPDC_OFS_SRC, 32'h1);
    u_prog.scan(4'h0, 4'h1, 1'b0);
    repeat (16) u_prog.scan(4'h0, 4'h0, 1'b0);
    pins(2, 32'h05);
    close_out();
  end
endmodule
